// ---- common/rcr_consts.svh ----
// Register indices, field positions, counts and reset values of the regulator register bank
`ifndef RCR_CONSTS_SVH
`define RCR_CONSTS_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define RCR_IDX_SW_PRI    8'h40
`define RCR_IDX_SW_SEC    8'h41
`define RCR_IDX_SW_CTL    8'h42
`define RCR_IDX_L5_SET    8'h50
`define RCR_IDX_L5_CTL    8'h51
`define RCR_IDX_L6_SET    8'h58
`define RCR_IDX_L6_CTL    8'h59
`define RCR_IDX_L7_SET    8'h60
`define RCR_IDX_L7_CTL    8'h61
`define RCR_IDX_L8_SET    8'h68
`define RCR_IDX_L8_CTL    8'h69
`define RCR_IDX_IRQ_STAT  8'hf0
`define RCR_IDX_IRQ_MASK  8'hf1
// ==========================================================
// Field positions of control registers
`define RCR_BIT_ON        7
`define RCR_BIT_PHASE     2
`define RCR_BIT_DRAIN     2
`define RCR_BIT_FLTEN     1
`define RCR_BIT_PGOOD     0
// ==========================================================
// Counts and reset values
`define RCR_NUM_REG       5
`define RCR_NUM_LDO       4
`define RCR_RST_OUTPUT_SETPOINT      6'h00
`define RCR_RST_BIT       1'b0
`define RCR_RST_IRQ       5'h00
`endif

// ---- common/rcr_pkg.sv ----
// Types shared by the regulator register bank modules
package rcr_pkg;
  typedef logic [5:0] rcr_vcode_type;  // Six-bit output voltage code
  typedef logic [7:0] rcr_byte_type;   // One register byte
  typedef logic [7:0] rcr_index_type;  // Register index (word address)
endpackage : rcr_pkg

// ---- hdl/rcr_ldo_reg.sv ----
// Setpoint and control register pair of one linear regulator
`timescale 1ns/10ps
`default_nettype none
`include "rcr_consts.svh"
module rcr_ldo_reg (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               wr_set,
  input  wire logic               wr_ctl,
  input  wire rcr_pkg::rcr_byte_type wdata,
  input  wire logic               power_good,
  output logic                    enable_q,
  output logic                    drain_q,
  output logic                    fault_en_q,
  output rcr_pkg::rcr_vcode_type  setpoint_q,
  output rcr_pkg::rcr_byte_type   set_rd,
  output rcr_pkg::rcr_byte_type   ctl_rd
);
  import rcr_pkg::*;

  // ==========================================================
  // Setpoint field, low six bits only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      setpoint_q <= `RCR_RST_OUTPUT_SETPOINT;
    end else if (wr_set) begin
      setpoint_q <= wdata[5:0];
    end
  end

  // ==========================================================
  // Control bits: enable, drain in shutdown, fault gate
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable_q   <= `RCR_RST_BIT;
      drain_q    <= `RCR_RST_BIT;
      fault_en_q <= `RCR_RST_BIT;
    end else if (wr_ctl) begin
      enable_q   <= wdata[`RCR_BIT_ON];
      drain_q    <= wdata[`RCR_BIT_DRAIN];
      fault_en_q <= wdata[`RCR_BIT_FLTEN];
    end
  end

  // Read views, reserved bits as zero
  assign set_rd = {2'b00, setpoint_q};
  assign ctl_rd = {enable_q, 4'h0, drain_q, fault_en_q, power_good};

  // ==========================================================
  // Checks
  chk_ldo_setpoint_load : assert property (@(posedge sys_clk) disable iff (rst)
    wr_set |=> setpoint_q == $past(wdata[5:0]))
    else $error("linear setpoint not loaded");
  chk_ldo_drain_load : assert property (@(posedge sys_clk) disable iff (rst)
    wr_ctl |=> drain_q == $past(wdata[`RCR_BIT_DRAIN]) && enable_q == $past(wdata[7]))
    else $error("linear drain or enable not loaded");
  chk_ldo_ctl_reserved : assert property (@(posedge sys_clk) disable iff (rst)
    wr_ctl |=> ctl_rd[6:3] == 4'h0 && set_rd[7:6] == 2'b00)
    else $error("linear reserved bits not zero");
endmodule : rcr_ldo_reg
`default_nettype wire

// ---- hdl/rcr_top.sv ----
// Regulator control register bank with APB slave and fault interrupt
`timescale 1ns/10ps
`default_nettype none
`include "rcr_consts.svh"
//
// Contract
// - Voltage select high picks secondary setpoint
// - Voltage select low picks primary setpoint
// - Linear regulators use own six-bit setpoint
// - Control bit 7 enables the regulator
// - Switcher bit 2 shifts phase 180 degrees
// - Control bit 1 gates faults into interrupts
// - Control bit 0 reads power good
// - Linear bit 2 discharges output in shutdown
module rcr_top (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [9:0]            paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Regulator side
  input  wire logic                  voltage_select_pin,
  input  wire logic [4:0]            power_good,
  input  wire logic [4:0]            fault_event,
  output rcr_pkg::rcr_vcode_type     sw_output_setpoint,
  output logic                       sw_enable,
  output logic                       sw_phase_shift,
  output logic [23:0]                ldo_output_setpoint,
  output logic [3:0]                 ldo_enable,
  output logic [3:0]                 ldo_output_drain,
  output logic                       irq
);
  import rcr_pkg::*;

  // ==========================================================
  // Register indices of the linear regulators
  localparam rcr_index_type LDO_SET_IDX [`RCR_NUM_LDO] = '{
    `RCR_IDX_L5_SET, `RCR_IDX_L6_SET, `RCR_IDX_L7_SET, `RCR_IDX_L8_SET};
  localparam rcr_index_type LDO_CTL_IDX [`RCR_NUM_LDO] = '{
    `RCR_IDX_L5_CTL, `RCR_IDX_L6_CTL, `RCR_IDX_L7_CTL, `RCR_IDX_L8_CTL};

  // ==========================================================
  // Declarations
  rcr_index_type           idx;             // Word index from address
  logic                    word_ok;         // Address is word aligned
  logic                    rd_hit;          // Index maps to a register
  logic                    hit;             // Mapped and aligned
  rcr_byte_type            rd_byte;         // Selected read byte
  logic                    access;          // Access phase completes
  logic                    wr_acc;          // Write with low lane strobed
  logic                    rd_setup;        // Read setup cycle
  rcr_byte_type            wbyte;           // Low write lane
  logic [31:0]             prdata_q;        // Registered read data
  rcr_vcode_type           sw_pri_q;        // Switcher primary setpoint
  rcr_vcode_type           sw_sec_q;        // Switcher secondary setpoint
  logic                    sw_en_q;         // Switcher enable
  logic                    sw_phase_q;      // Switcher phase select
  logic                    sw_fe_q;         // Switcher fault gate
  rcr_vcode_type           sw_vcode_q;      // Selected switcher code
  logic [4:0]              fault_gate;      // Per regulator fault gate
  logic [4:0]              stat_q;          // Sticky fault status
  logic [4:0]              stat_d;          // Next sticky status
  logic [4:0]              mask_q;          // Interrupt mask
  logic [4:0]              w1c;             // Clear request bits
  logic [`RCR_NUM_LDO-1:0] ldo_wr_set;      // Setpoint write strobes
  logic [`RCR_NUM_LDO-1:0] ldo_wr_ctl;      // Control write strobes
  logic [`RCR_NUM_LDO-1:0] ldo_fe;          // Linear fault gates
  rcr_byte_type            ldo_set_rd [`RCR_NUM_LDO];  // Linear setpoint views
  rcr_byte_type            ldo_ctl_rd [`RCR_NUM_LDO];  // Linear control views

  // ==========================================================
  // Bus phase decode
  assign idx      = paddr[9:2];
  assign word_ok  = (paddr[1:0] == 2'b00);
  assign hit      = rd_hit & word_ok;
  assign access   = psel & penable;
  assign wr_acc   = access & pwrite & pstrb[0] & hit;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wbyte    = pwdata[7:0];

  // Zero wait state slave
  assign pready  = 1'b1;
  // Error on unmapped or unaligned access
  assign pslverr = access & ~hit;
  assign prdata  = prdata_q;

  // ==========================================================
  // Read multiplexer
  always_comb begin
    rd_hit  = 1'b0;
    rd_byte = 8'h00;
    if (idx == `RCR_IDX_SW_PRI) begin
      // Primary setpoint, reserved top bits zero
      rd_hit  = 1'b1;
      rd_byte = {2'b00, sw_pri_q};
    end else if (idx == `RCR_IDX_SW_SEC) begin
      // Secondary setpoint, reserved top bits zero
      rd_hit  = 1'b1;
      rd_byte = {2'b00, sw_sec_q};
    end else if (idx == `RCR_IDX_SW_CTL) begin
      // Switcher control with live power good
      rd_hit  = 1'b1;
      rd_byte = {sw_en_q, 4'h0, sw_phase_q, sw_fe_q, power_good[0]};
    end else if (idx == `RCR_IDX_IRQ_STAT) begin
      // Sticky fault status
      rd_hit  = 1'b1;
      rd_byte = {3'h0, stat_q};
    end else if (idx == `RCR_IDX_IRQ_MASK) begin
      // Interrupt mask
      rd_hit  = 1'b1;
      rd_byte = {3'h0, mask_q};
    end else begin
      // Linear regulator pairs
      for (int i = 0; i < `RCR_NUM_LDO; i++) begin
        if (idx == LDO_SET_IDX[i]) begin
          rd_hit  = 1'b1;
          rd_byte = ldo_set_rd[i];
        end else if (idx == LDO_CTL_IDX[i]) begin
          rd_hit  = 1'b1;
          rd_byte = ldo_ctl_rd[i];
        end
      end
    end
  end

  // ==========================================================
  // Read data captured in the setup cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      // Unmapped reads return zero
      prdata_q <= hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Switcher setpoint registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sw_pri_q <= `RCR_RST_OUTPUT_SETPOINT;
      sw_sec_q <= `RCR_RST_OUTPUT_SETPOINT;
    end else if (wr_acc) begin
      if (idx == `RCR_IDX_SW_PRI) begin
        sw_pri_q <= wbyte[5:0];
      end else if (idx == `RCR_IDX_SW_SEC) begin
        sw_sec_q <= wbyte[5:0];
      end
    end
  end

  // ==========================================================
  // Switcher control register, writable bits only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sw_en_q    <= `RCR_RST_BIT;
      sw_phase_q <= `RCR_RST_BIT;
      sw_fe_q    <= `RCR_RST_BIT;
    end else if (wr_acc && idx == `RCR_IDX_SW_CTL) begin
      sw_en_q    <= wbyte[`RCR_BIT_ON];
      sw_phase_q <= wbyte[`RCR_BIT_PHASE];
      sw_fe_q    <= wbyte[`RCR_BIT_FLTEN];
    end
  end

  // ==========================================================
  // Switcher output code follows the select pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sw_vcode_q <= `RCR_RST_OUTPUT_SETPOINT;
    end else if (voltage_select_pin) begin
      sw_vcode_q <= sw_sec_q;
    end else begin
      sw_vcode_q <= sw_pri_q;
    end
  end

  assign sw_output_setpoint = sw_vcode_q;
  assign sw_enable          = sw_en_q;
  assign sw_phase_shift     = sw_phase_q;

  // ==========================================================
  // Linear regulator register pairs
  for (genvar g = 0; g < `RCR_NUM_LDO; g++) begin : g_ldo
    assign ldo_wr_set[g] = wr_acc & (idx == LDO_SET_IDX[g]);
    assign ldo_wr_ctl[g] = wr_acc & (idx == LDO_CTL_IDX[g]);
    rcr_ldo_reg u_ldo (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .wr_set     (ldo_wr_set[g]),
      .wr_ctl     (ldo_wr_ctl[g]),
      .wdata      (wbyte),
      .power_good (power_good[g+1]),
      .enable_q   (ldo_enable[g]),
      .drain_q    (ldo_output_drain[g]),
      .fault_en_q (ldo_fe[g]),
      .setpoint_q (ldo_output_setpoint[6*g +: 6]),
      .set_rd     (ldo_set_rd[g]),
      .ctl_rd     (ldo_ctl_rd[g])
    );
  end

  // ==========================================================
  // Fault events gated per regulator
  assign fault_gate = {ldo_fe, sw_fe_q};

  // Clear bits from a status write
  assign w1c = (wr_acc && idx == `RCR_IDX_IRQ_STAT) ? wbyte[4:0] : 5'h00;

  // Set wins over a clear in the same cycle
  assign stat_d = (stat_q & ~w1c) | (fault_event & fault_gate);

  // ==========================================================
  // Sticky status register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_q <= `RCR_RST_IRQ;
    end else begin
      stat_q <= stat_d;
    end
  end

  // ==========================================================
  // Interrupt mask register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_q <= `RCR_RST_IRQ;
    end else if (wr_acc && idx == `RCR_IDX_IRQ_MASK) begin
      mask_q <= wbyte[4:0];
    end
  end

  // Level interrupt from unmasked status
  assign irq = |(stat_q & mask_q);

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Pin high selects secondary code
  chk_sw_sec_select : assert property (
    voltage_select_pin |=> sw_output_setpoint == $past(sw_sec_q))
    else $error("secondary setpoint not selected");

  // Pin low selects primary code
  chk_sw_pri_select : assert property (
    !voltage_select_pin |=> sw_output_setpoint == $past(sw_pri_q))
    else $error("primary setpoint not selected");

  // Write to control register drives the enable
  chk_sw_enable_write : assert property (
    wr_acc && idx == `RCR_IDX_SW_CTL |=> sw_enable == $past(pwdata[7]))
    else $error("switcher enable not written");

  // Phase bit reaches the pin and holds
  sequence s_phase_write;
    wr_acc && idx == `RCR_IDX_SW_CTL;
  endsequence
  chk_sw_phase_hold : assert property (
    s_phase_write ##1 !(wr_acc && idx == `RCR_IDX_SW_CTL)
      |-> sw_phase_shift == $past(pwdata[`RCR_BIT_PHASE]))
    else $error("switcher phase not held");

  // Status bit 0 rises only on a gated switcher fault
  chk_fault_gate : assert property (
    $rose(stat_q[0]) |-> $past(fault_event[0] && sw_fe_q))
    else $error("fault raised while gate off");

  // Power good read reflects the input
  chk_pgood_read : assert property (
    rd_setup && word_ok && idx == `RCR_IDX_SW_CTL
      |=> prdata[0] == $past(power_good[0]) && prdata[6:3] == 4'h0)
    else $error("power good read wrong");

  // Reserved setpoint bits read zero on every secondary setpoint read
  chk_reserved_zero : assert property (
    rd_setup && word_ok && idx == `RCR_IDX_SW_SEC
      |=> prdata[31:6] == 26'h0)
    else $error("reserved bits not zero");

  // Status stays set until cleared
  chk_status_sticky : assert property (
    stat_q[0] && !w1c[0] |=> stat_q[0])
    else $error("status bit lost");

  // Unmapped read answers with error and zero data
  chk_unmapped_error : assert property (
    rd_setup && !hit ##1 access |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  // Gated fault in the clearing cycle keeps the bit set
  chk_set_wins_clear : assert property (
    fault_event[1] && ldo_fe[0] && w1c[1] |=> stat_q[1])
    else $error("clear won over a fault in the same cycle");

  // Clearing write without a fault empties the bit
  chk_status_clear : assert property (
    w1c[1] && !(fault_event[1] && ldo_fe[0]) |=> !stat_q[1])
    else $error("status bit not cleared");

  // Switcher fault gate follows its write
  chk_sw_gate_write : assert property (
    wr_acc && idx == `RCR_IDX_SW_CTL |=> sw_fe_q == $past(pwdata[`RCR_BIT_FLTEN]))
    else $error("switcher fault gate not written");

  // Mask register follows its write
  chk_mask_write : assert property (
    wr_acc && idx == `RCR_IDX_IRQ_MASK |=> mask_q == $past(pwdata[4:0]))
    else $error("interrupt mask not written");

  // Linear codes ignore the select pin
  chk_ldo_pin_free : assert property (
    $changed(voltage_select_pin) && !(|ldo_wr_set) |=> $stable(ldo_output_setpoint))
    else $error("linear code moved with the select pin");

  // Refused write: unmapped, unaligned, or low lane not strobed
  // Linear setpoints, linear enables and the interrupt mask may not move
  sequence s_refused_write;
    access && pwrite && (!hit || !pstrb[0]);
  endsequence
  chk_refused_write : assert property (
    s_refused_write |=> $stable(ldo_output_setpoint) && $stable(ldo_enable) && $stable(mask_q))
    else $error("refused write changed a register");

  // Upper lanes of read data stay zero
  chk_rd_upper_zero : assert property (
    access |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");

  // Mapped aligned access is never refused
  chk_mapped_no_error : assert property (
    access && hit |-> !pslverr)
    else $error("mapped access refused");
endmodule : rcr_top
`default_nettype wire

// ---- testbench/rcr_top_tb_top.sv ----
// Self-checking testbench of the regulator register bank
`timescale 1ns/10ps
`default_nettype none
`include "rcr_consts.svh"
module rcr_top_tb_top;
  import rcr_pkg::*;
  // ==========================================================
  // Bench signals
  logic          sys_clk  = 1'b0;    // 200 MHz clock
  logic          rst      = 1'b1;    // Synchronous reset
  logic          psel     = 1'b0;    // APB select
  logic          penable  = 1'b0;    // APB access phase
  logic          pwrite   = 1'b0;    // APB direction
  logic [9:0]    paddr    = 10'h000; // Byte address
  logic [31:0]   pwdata   = 32'h0;   // Write data
  logic [3:0]    pstrb    = 4'hf;    // Byte strobes
  logic          pin      = 1'b0;    // Voltage select pin
  logic [4:0]    pgood    = 5'h00;   // Power good inputs
  logic [4:0]    fault    = 5'h00;   // Fault events
  logic [31:0]   prdata;             // Read data
  logic          pready;             // Access done
  logic          pslverr;            // Access refused
  rcr_vcode_type sw_set;             // Switcher code
  logic          sw_en;              // Switcher on
  logic          sw_ph;              // Switcher phase
  logic [23:0]   ldo_set;            // Linear codes
  logic [3:0]    ldo_en;             // Linear on
  logic [3:0]    ldo_dr;             // Linear drain
  logic          irq;                // Interrupt
  int            errors   = 0;       // Mismatches
  int            compares = 0;       // Comparisons
  int            cycles   = 0;       // Timeout counter
  logic [31:0]   rd;                 // Last read data
  logic          last_err;           // Last pslverr
  rcr_index_type set_idx [4] = '{`RCR_IDX_L5_SET, `RCR_IDX_L6_SET, `RCR_IDX_L7_SET,
                                 `RCR_IDX_L8_SET};
  rcr_index_type ctl_idx [4] = '{`RCR_IDX_L5_CTL, `RCR_IDX_L6_CTL, `RCR_IDX_L7_CTL,
                                 `RCR_IDX_L8_CTL};
  // ==========================================================
  // Design under test
  rcr_top DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .voltage_select_pin(pin), .power_good(pgood),
    .fault_event(fault), .sw_output_setpoint(sw_set), .sw_enable(sw_en),
    .sw_phase_shift(sw_ph), .ldo_output_setpoint(ldo_set), .ldo_enable(ldo_en),
    .ldo_output_drain(ldo_dr), .irq(irq));
  // ==========================================================
  // Clock and hang guard
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end
  // ==========================================================
  // Tasks
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input rcr_index_type idx, input logic [7:0] d,
                     input logic [3:0] s, input logic [1:0] lo);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, lo};
    pwdata  <= {24'h000000, d};
    pstrb   <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input rcr_index_type idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'hf, 2'b00);
  endtask : wr
  task automatic rdc(input string name, input rcr_index_type idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00, 4'hf, 2'b00);
    check(name, {24'h0, e}, rd);
  endtask : rdc
  // Let outputs settle past the next n edges
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle
  // Pulse all fault events for one cycle
  task automatic pulse();
    @(posedge sys_clk);
    fault <= 5'h1f;
    @(posedge sys_clk);
    fault <= 5'h00;
  endtask : pulse
  task automatic end_sim();
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // ==========================================================
  // Test sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values and reserved bits of linear registers
    for (int g = 0; g < 4; g++) begin
      rdc("ldo ctl reset", ctl_idx[g], 8'h00);
      wr(set_idx[g], 8'hc5 + 8'(g * 8));
      rdc("ldo setpoint", set_idx[g], 8'h05 + 8'(g * 8));
    end
    pin <= 1'b1;
    settle(2);
    for (int g = 0; g < 4; g++)
      check("ldo code", 6'h05 + 6'(g * 8), ldo_set[6 * g +: 6]);
    // Linear control bits with live power good
    @(posedge sys_clk);
    pgood <= 5'b10100;
    for (int g = 0; g < 4; g++) begin
      wr(ctl_idx[g], 8'hff);
      rdc("ldo ctl all", ctl_idx[g], 8'h86 | 8'(pgood[g + 1]));
    end
    settle(1);
    check("ldo enable", 4'hf, ldo_en);
    check("ldo drain", 4'hf, ldo_dr);
    for (int g = 0; g < 4; g++) wr(ctl_idx[g], 8'h04);
    settle(1);
    check("ldo enable off", 4'h0, ldo_en);
    check("ldo drain kept", 4'hf, ldo_dr);
    // Switcher control
    @(posedge sys_clk);
    pgood <= 5'b00001;
    wr(`RCR_IDX_SW_CTL, 8'hff);
    rdc("sw ctl", `RCR_IDX_SW_CTL, 8'h87);
    settle(1);
    check("sw enable", 1'b1, sw_en);
    check("sw phase", 1'b1, sw_ph);
    @(posedge sys_clk);
    pgood <= 5'b00000;
    wr(`RCR_IDX_SW_CTL, 8'h80);
    rdc("sw ctl off", `RCR_IDX_SW_CTL, 8'h80);
    settle(1);
    check("sw phase off", 1'b0, sw_ph);
    // Setpoint selection by the pin
    wr(`RCR_IDX_SW_PRI, 8'hca);
    wr(`RCR_IDX_SW_SEC, 8'hf5);
    rdc("sw secondary", `RCR_IDX_SW_SEC, 8'h35);
    settle(2);
    check("sw code high", 6'h35, sw_set);
    @(posedge sys_clk);
    pin <= 1'b0;
    settle(2);
    check("sw code low", 6'h0a, sw_set);
    // Fault gating, masking and clearing
    wr(`RCR_IDX_SW_CTL, 8'h00);
    for (int g = 0; g < 4; g++) wr(ctl_idx[g], g == 0 ? 8'h02 : 8'h00);
    wr(`RCR_IDX_IRQ_MASK, 8'hff);
    rdc("mask", `RCR_IDX_IRQ_MASK, 8'h1f);
    check("sw enable off", 1'b0, sw_en);
    pulse();
    rdc("status gated", `RCR_IDX_IRQ_STAT, 8'h02);
    check("irq set", 1'b1, irq);
    wr(`RCR_IDX_IRQ_STAT, 8'hfd);
    rdc("status kept", `RCR_IDX_IRQ_STAT, 8'h02);
    wr(`RCR_IDX_IRQ_STAT, 8'h02);
    settle(1);
    check("irq clear", 1'b0, irq);
    wr(`RCR_IDX_IRQ_MASK, 8'h00);
    pulse();
    settle(1);
    check("irq masked", 1'b0, irq);
    wr(`RCR_IDX_IRQ_MASK, 8'h02);
    settle(1);
    check("irq unmasked", 1'b1, irq);
    wr(`RCR_IDX_IRQ_STAT, 8'h02);
    // Fault held through a clearing write: the set wins
    fault <= 5'h02;
    wr(`RCR_IDX_IRQ_STAT, 8'h02);
    fault <= 5'h00;
    rdc("status set wins", `RCR_IDX_IRQ_STAT, 8'h02);
    wr(`RCR_IDX_IRQ_STAT, 8'h02);
    // Refused accesses
    apb(1'b0, 8'h43, 8'h00, 4'hf, 2'b00);
    check("unmapped data", 32'h0, rd);
    check("unmapped err", 1'b1, last_err);
    apb(1'b1, `RCR_IDX_L5_SET, 8'h2a, 4'hf, 2'b01);
    check("unaligned err", 1'b1, last_err);
    apb(1'b1, `RCR_IDX_L5_SET, 8'h3f, 4'h0, 2'b00);
    rdc("strobe off", `RCR_IDX_L5_SET, 8'h05);
    check("mapped err", 1'b0, last_err);
    end_sim();
  end
endmodule : rcr_top_tb_top
`default_nettype wire
